// File: verilog/ddu_params.svh
// Constants for the dual DAC update and power-up controller
`ifndef DDU_PARAMS_SVH
`define DDU_PARAMS_SVH
`define DDU_CLK_MHZ 20
`define DDU_PU_ONE_US 5
`define DDU_PU_BOTH_5V_US 12
`define DDU_PU_BOTH_3V_US 30
`define DDU_PU_ONE_CYC (`DDU_PU_ONE_US * `DDU_CLK_MHZ)
`define DDU_PU_BOTH_5V_CYC (`DDU_PU_BOTH_5V_US * `DDU_CLK_MHZ)
`define DDU_PU_BOTH_3V_CYC (`DDU_PU_BOTH_3V_US * `DDU_CLK_MHZ)
`define DDU_CNT_W 10
`define DDU_CMD_WRITE 4'h0
`define DDU_CMD_UPDATE 4'h1
`define DDU_CMD_WR_UPD 4'h3
`define DDU_CMD_PDOWN 4'h4
`define DDU_CMD_NOP 4'hF
`define DDU_SEL_A 4'h0
`define DDU_SEL_B 4'h1
`define DDU_SEL_ALL 4'hF
`define DDU_CODE_RESET 16'h0000
`endif

// File: verilog/ddu_pkg.sv
// Types shared by the dual DAC update controller
package ddu_pkg;
    // One received 24-bit word split into its fields
    typedef struct packed {
        logic [3:0] command_field;
        logic [3:0] channel_select_field;
        logic [15:0] data;
    } ddu_word_t;
    // Per-channel register pair
    typedef struct packed {
        logic [15:0] input_reg;
        logic [15:0] dac_reg;
    } ddu_chan_t;
endpackage

// File: verilog/ddu_load_sync.sv
// Synchroniser and edge detector for the asynchronous load pin
`timescale 1ns/10ps
module ddu_load_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Pin in
    input wire logic async_load_n,
    // Synchronised outputs
    output logic load_low,
    output logic load_fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Three flops; pin idles high so reset to high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= async_load_n;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Level and falling edge only from the second flop onward
    assign load_low = !sync_r;
    assign load_fall = prev_r && !sync_r;
endmodule

// File: verilog/ddu_update_ctrl.sv
// Update and power-up control for a dual channel DAC
// How it works
// - One channel waking from power-down delays settling by 5 us.
// - Both down: bias off, delay 12 us at 5 V, 30 us at 3 V.
// - Load strobe does not update while a word is being shifted in.
// - With the word complete, load low copies every input register to DAC.
// - Load pulse during a partial word powers up channels, leaves outputs alone.
// - Load still low at word end: run the word's command, then update all.
// - Load low powers both channels up at once, regardless of bus activity.
// - Load low at the third byte's ninth clock blocks that word's power-down.
// - Load held high disables async updates; only serial updates remain.
// - First byte is command then select; next two are data, MSB first.
// - Command 0100b powers down selected channels and ignores the data.
// - Any update of a channel also powers that channel up.
// - Power-down leaves input and DAC registers untouched.
`timescale 1ns/10ps
`include "ddu_params.svh"
module ddu_update_ctrl
    import ddu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Serial write path: busy while a word shifts in, word_done pulses at its end
    input wire logic word_busy,
    input wire logic word_done,
    input wire ddu_word_t word_in,
    // Load strobe and supply strap (1 = 5 V supply)
    input wire logic async_load_n,
    input wire logic supply_5v,
    // Channel outputs
    output logic [15:0] dac_a_code,
    output logic [15:0] dac_b_code,
    output logic [1:0] chan_powered,
    output logic [1:0] chan_settling
);
    ddu_chan_t chan_r [2];
    logic [1:0] pwr_r;
    logic [1:0] pwr_nxt;
    logic [`DDU_CNT_W-1:0] wait_r [2];
    logic load_low;
    logic load_fall;
    logic [1:0] sel;
    logic is_wr;
    logic is_upd;
    logic is_pd;
    logic word_upd;
    logic async_upd;
    logic [1:0] upd_mask;
    logic [1:0] wake;
    logic [`DDU_CNT_W-1:0] both_cyc;

    // Pin synchroniser with level and falling-edge detectors
    ddu_load_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_load_n(async_load_n),
        .load_low(load_low),
        .load_fall(load_fall)
    );

    // Decode the completed word; reserved selects hit nothing
    always_comb begin
        case (word_in.channel_select_field)
            `DDU_SEL_A: sel = 2'h1;
            `DDU_SEL_B: sel = 2'h2;
            `DDU_SEL_ALL: sel = 2'h3;
            default: sel = 2'h0;
        endcase
    end
    assign is_wr = word_done && (word_in.command_field == `DDU_CMD_WRITE
        || word_in.command_field == `DDU_CMD_WR_UPD);
    assign is_upd = word_done && (word_in.command_field == `DDU_CMD_UPDATE
        || word_in.command_field == `DDU_CMD_WR_UPD);
    // Power-down suppressed when load is low at the word's last clock
    assign is_pd = word_done && word_in.command_field == `DDU_CMD_PDOWN
        && !load_low;

    // Async update: edge while idle, or level still low as the word ends
    assign async_upd = load_low && ((load_fall && !word_busy) || word_done);
    assign word_upd = is_upd;
    assign upd_mask = async_upd ? 2'h3 : (word_upd ? sel : 2'h0);

    // Wake on any update or on the load level itself
    assign wake = (load_low ? 2'h3 : 2'h0) | upd_mask;
    assign pwr_nxt = (pwr_r | wake) & ~(is_pd ? sel & ~wake : 2'h0);

    // Input and DAC registers; power-down never touches them
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    chan_r[i] <= {`DDU_CODE_RESET, `DDU_CODE_RESET};
                end else begin
                    // DAC takes the word's data directly so write-and-update copies new data
                    if (is_wr && sel[i]) begin
                        chan_r[i].input_reg <= word_in.data;
                    end
                    if (upd_mask[i]) begin
                        chan_r[i].dac_reg <= (is_wr && sel[i]) ? word_in.data
                            : chan_r[i].input_reg;
                    end
                end
            end
            // Settling counter starts when a down channel wakes
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    wait_r[i] <= '0;
                end else if (!pwr_r[i] && pwr_nxt[i]) begin
                    wait_r[i] <= (pwr_r == 2'h0) ? both_cyc
                        : `DDU_CNT_W'(`DDU_PU_ONE_CYC);
                end else if (wait_r[i] != '0) begin
                    wait_r[i] <= wait_r[i] - 1'b1;
                end
            end
            assign chan_settling[i] = wait_r[i] != '0;
        end
    endgenerate

    // Bias wake time depends on the supply strap
    assign both_cyc = supply_5v ? `DDU_CNT_W'(`DDU_PU_BOTH_5V_CYC)
        : `DDU_CNT_W'(`DDU_PU_BOTH_3V_CYC);

    // Power state; channels start powered down until first update or load low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_r <= 2'h0;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    assign dac_a_code = chan_r[0].dac_reg;
    assign dac_b_code = chan_r[1].dac_reg;
    assign chan_powered = pwr_r;

    // Checks
    sequence s_idle_fall;
        load_fall && !word_busy;
    endsequence
    a_idle_load_update: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_idle_fall |=> dac_a_code == $past(chan_r[0].input_reg))
        else $error("Idle load did not update channel A");
    a_busy_no_update: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_busy && !word_done) |=> $stable(dac_a_code) && $stable(dac_b_code))
        else $error("DAC changed while word in progress");
    a_load_powers_up: assert property (@(posedge core_clk) disable iff (!reset_n)
        load_low |=> chan_powered == 2'h3)
        else $error("Load low did not power up");
    a_pd_blocked: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_done && load_low) |=> chan_powered == 2'h3)
        else $error("Power-down not suppressed");
    a_one_settle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!pwr_r[0] && pwr_r[1] && pwr_nxt[0]) |=> wait_r[0] == `DDU_CNT_W'(`DDU_PU_ONE_CYC))
        else $error("Single wake delay wrong");
    a_both_settle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (pwr_r == 2'h0 && pwr_nxt[0] && supply_5v)
        |=> wait_r[0] == `DDU_CNT_W'(`DDU_PU_BOTH_5V_CYC))
        else $error("Bias wake delay wrong");
    a_pd_keeps_regs: assert property (@(posedge core_clk) disable iff (!reset_n)
        (is_pd && !is_wr) |=> $stable(dac_a_code) && $stable(dac_b_code))
        else $error("Power-down changed registers");
    a_high_no_async: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!load_low && !word_done) |=> $stable(dac_a_code))
        else $error("Update without load or command");
    a_late_load_exec: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_done && load_low) |=> dac_b_code == $past(is_wr && sel[1]
            ? word_in.data : chan_r[1].input_reg))
        else $error("Late load did not execute and update");

    // Bias wake at the low supply strap takes the longest count
    a_both_settle_3v: assert property (@(posedge core_clk) disable iff (!reset_n)
        (pwr_r == 2'h0 && pwr_nxt[0] && !supply_5v)
        |=> wait_r[0] == `DDU_CNT_W'(`DDU_PU_BOTH_3V_CYC))
        else $error("Bias wake delay at low supply wrong");

    // A falling edge is only ever reported together with a low level
    a_fall_is_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        load_fall |-> load_low)
        else $error("Load edge without load level");

    // A serial update of channel A alone must leave channel B untouched
    a_sel_a_only: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_upd && !async_upd && sel == 2'h1) |=> $stable(dac_b_code))
        else $error("Update of A moved B");

    // No operation with load high leaves codes and power state where they were
    a_nop_static: assert property (@(posedge core_clk) disable iff (!reset_n)
        (word_done && word_in.command_field == `DDU_CMD_NOP && !load_low)
        |=> $stable(dac_a_code) && $stable(dac_b_code) && $stable(chan_powered))
        else $error("No operation changed state");

    // Per-channel checks on writes, wakes, power-down and the countdown
    genvar j;
    generate
        for (j = 0; j < 2; j++) begin : g_chk
            // A write lands in the input register of each selected channel
            a_wr_input: assert property (@(posedge core_clk) disable iff (!reset_n)
                (is_wr && sel[j]) |=> chan_r[j].input_reg == $past(word_in.data))
                else $error("Write did not reach input register");

            // Whatever updates a channel also leaves it powered
            a_upd_power: assert property (@(posedge core_clk) disable iff (!reset_n)
                upd_mask[j] |=> chan_powered[j])
                else $error("Updated channel not powered");

            // An unblocked power-down turns the selected channel off
            a_pd_down: assert property (@(posedge core_clk) disable iff (!reset_n)
                (is_pd && sel[j]) |=> !chan_powered[j])
                else $error("Power-down had no effect");

            // Waking while the other channel runs uses the short delay
            a_one_wake: assert property (@(posedge core_clk) disable iff (!reset_n)
                (!pwr_r[j] && pwr_r[1-j] && pwr_nxt[j])
                |=> wait_r[j] == `DDU_CNT_W'(`DDU_PU_ONE_CYC))
                else $error("Single wake delay wrong");

            // Settling counts down one per clock until it reaches zero
            a_count_down: assert property (@(posedge core_clk) disable iff (!reset_n)
                (wait_r[j] != '0 && !(!pwr_r[j] && pwr_nxt[j]))
                |=> wait_r[j] == $past(wait_r[j]) - 1'b1)
                else $error("Settling counter skipped");
        end
    endgenerate
endmodule

// File: tb/ddu_word_src.sv
// Serial write path model: shifts one word in, then marks its end
`timescale 1ns/10ps
module ddu_word_src
    import ddu_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request from the bench
    input wire logic go,
    input wire ddu_word_t word,
    // Towards the controller
    output logic word_busy,
    output logic word_done,
    output ddu_word_t word_in
);
    logic [4:0] cnt_r;
    initial begin
        cnt_r = 5'h00;
        word_busy = 1'b0;
        word_done = 1'b0;
        word_in = 24'h000000;
    end
    // Busy for three nine-slot bytes, then a one-cycle done with the word
    always @(posedge core_clk) begin
        word_done <= 1'b0;
        word_in <= ~word_in; // Not valid outside done, so keep it moving
        if (go && cnt_r == 5'h00) begin
            cnt_r <= 5'h1B;
            word_busy <= 1'b1;
        end else if (cnt_r == 5'h01) begin
            cnt_r <= 5'h00;
            word_busy <= 1'b0;
            word_done <= 1'b1;
            word_in <= word;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule

// File: tb/tb_ddu_update_ctrl.sv
// Self-checking bench for the dual DAC update controller
`timescale 1ns/10ps
module tb_ddu_update_ctrl
    import ddu_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0, go = 1'b0, async_load_n = 1'b1;
    logic supply_5v = 1'b1, word_busy, word_done, snap = 1'b0;
    ddu_word_t wrd = 24'h000000, word_in;
    logic [15:0] dac_a_code, dac_b_code, d1, d2, d3, d4;
    logic [1:0] chan_powered, chan_settling;
    logic [33:0] exp_q[$];
    int failures = 0, n_checks = 0;
    always #25 core_clk = ~core_clk;
    ddu_word_src src (.core_clk(core_clk), .go(go), .word(wrd), .word_busy(word_busy),
        .word_done(word_done), .word_in(word_in));
    ddu_update_ctrl dut (.core_clk(core_clk), .reset_n(reset_n), .word_busy(word_busy),
        .word_done(word_done), .word_in(word_in), .async_load_n(async_load_n),
        .supply_5v(supply_5v), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
        .chan_powered(chan_powered), .chan_settling(chan_settling));
    task check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("failures %0d, n_checks %0d", failures, n_checks);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Monitor: compare the oldest note when a result is flagged
    always @(posedge core_clk) begin
        if (snap) check({dac_a_code, dac_b_code, chan_powered}, exp_q.pop_front());
    end
    task start(input logic [3:0] cmd, input logic [3:0] sel, input logic [15:0] d);
        wrd <= {cmd, sel, d};
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask
    // Bounded wait for the end of the word
    task wait_done;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (word_done !== 1'b1 && n < 60);
        if (n >= 60) begin
            failures++;
            end_of_test();
        end
    endtask
    task send(input logic [3:0] cmd, input logic [3:0] sel, input logic [15:0] d);
        start(cmd, sel, d);
        wait_done();
    endtask
    task note(input logic [15:0] a, input logic [15:0] b, input logic [1:0] p);
        repeat (2) @(posedge core_clk);
        exp_q.push_back({a, b, p});
        snap <= 1'b1;
        @(posedge core_clk);
        snap <= 1'b0;
        @(posedge core_clk);
    endtask
    // Count the cycles the settling flags stay up after an update
    task settle(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (chan_settling !== 2'b00 && n < 1000);
        if (n >= 1000) failures++;
        n = n - 1;
    endtask
    task load_pulse;
        async_load_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        async_load_n <= 1'b1;
    endtask
    initial begin
        int n;
        void'($urandom(82));
        d1 = 16'($urandom());
        d2 = 16'($urandom());
        d3 = 16'($urandom());
        d4 = 16'($urandom());
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        send(4'h3, 4'hF, d1);
        settle(n);
        check(34'(n), 34'd240);
        note(d1, d1, 2'b11);
        send(4'h4, 4'h0, d3);
        send(4'h1, 4'h0, d3);
        settle(n);
        check(34'(n), 34'd100);
        send(4'h0, 4'h1, d2);
        note(d1, d1, 2'b11);
        load_pulse();
        note(d1, d2, 2'b11);
        send(4'h4, 4'hF, d3);
        note(d1, d2, 2'b00);
        start(4'h0, 4'h0, d3);
        load_pulse();
        note(d1, d2, 2'b11);
        wait_done();
        note(d1, d2, 2'b11);
        async_load_n <= 1'b0;
        send(4'h0, 4'h0, d4);
        note(d4, d2, 2'b11);
        send(4'h4, 4'hF, d3);
        note(d4, d2, 2'b11);
        async_load_n <= 1'b1;
        supply_5v <= 1'b0;
        send(4'h4, 4'hF, d3);
        send(4'h1, 4'hF, d3);
        settle(n);
        check(34'(n), 34'd600);
        note(d4, d2, 2'b11);
        send(4'hF, 4'hF, d3);
        note(d4, d2, 2'b11);
        end_of_test();
    end
endmodule
